/* include/pecd_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the pin change detector.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef PECD_CONSTS_SVH
`define PECD_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PECD_OFF_B_RISE    12'h000
`define PECD_OFF_B_FALL    12'h004
`define PECD_OFF_B_FLAGS   12'h008
`define PECD_OFF_C_RISE    12'h00C
`define PECD_OFF_C_FALL    12'h010
`define PECD_OFF_C_FLAGS   12'h014
`define PECD_OFF_CTRL      12'h018
`define PECD_OFF_IRQ_STAT  12'h01C
`define PECD_OFF_IRQ_MASK  12'h020

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PECD_B_LSB         4
`define PECD_CTRL_IRQ_EN   0
`define PECD_CTRL_SUMMARY  1
`define PECD_EVT_B         0
`define PECD_EVT_C         1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PECD_RST_BYTE      8'h00
`define PECD_RST_EVT       2'h0
`define PECD_FILL_DONE     2'h3

`endif

/* include/pecd_pkg.sv */
// Purpose: Types shared by the pin change detector.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package pecd_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [7:0] pecd_byte_t;
  typedef logic [1:0] pecd_evt_t;

  // Register selected by the current bus address.
  typedef enum logic [3:0] {
    PECD_SEL_B_RISE,
    PECD_SEL_B_FALL,
    PECD_SEL_B_FLAGS,
    PECD_SEL_C_RISE,
    PECD_SEL_C_FALL,
    PECD_SEL_C_FLAGS,
    PECD_SEL_CTRL,
    PECD_SEL_IRQ_STAT,
    PECD_SEL_IRQ_MASK,
    PECD_SEL_NONE
  } pecd_sel_t;

endpackage

/* rtl/pecd_top.sv */
// Purpose: Edge detection with per-pin flags for port B pins 7..4 and port C pins 7..0.
// Assumes: Pin inputs synchronous to pclk; APB master waits for pready.
// Notes:   One wait state per APB access while pclk_en is high.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pecd_consts.svh"

module pecd_top #(
  parameter int B_PINS = 4,
  parameter int C_PINS = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                pclk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [B_PINS-1:0]   portb_pin_n,
  input  wire logic [C_PINS-1:0]   portc_pin_n,
  output logic                     change_summary_flag,
  output logic                     cpu_change_irq,
  output logic                     irq
);
  import pecd_pkg::*;

  localparam int N = B_PINS + C_PINS;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [N-1:0]   sync1;
  logic [N-1:0]   sync2;
  logic [N-1:0]   prev;
  logic [1:0]     fill;
  logic [N-1:0]   rise_en;
  logic [N-1:0]   fall_en;
  logic [N-1:0]   flags;
  logic [N-1:0]   next_flags;
  logic           change_irq_enable;
  pecd_evt_t      irq_status;
  pecd_evt_t      irq_mask;
  logic           ack;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  pecd_sel_t      sel;
  logic           access;
  logic           acc_wr;
  logic           wr_b_rise;
  logic           wr_b_fall;
  logic           wr_b_flags;
  logic           wr_c_rise;
  logic           wr_c_fall;
  logic           wr_c_flags;
  logic           wr_ctrl;
  logic           wr_stat;
  logic           wr_mask;
  logic [N-1:0]   wr_data_vec;
  logic [N-1:0]   flag_wr_mask;
  logic [31:0]    rd_mux;

  // Address to register select.
  assign sel = (paddr == `PECD_OFF_B_RISE)   ? PECD_SEL_B_RISE   :
               (paddr == `PECD_OFF_B_FALL)   ? PECD_SEL_B_FALL   :
               (paddr == `PECD_OFF_B_FLAGS)  ? PECD_SEL_B_FLAGS  :
               (paddr == `PECD_OFF_C_RISE)   ? PECD_SEL_C_RISE   :
               (paddr == `PECD_OFF_C_FALL)   ? PECD_SEL_C_FALL   :
               (paddr == `PECD_OFF_C_FLAGS)  ? PECD_SEL_C_FLAGS  :
               (paddr == `PECD_OFF_CTRL)     ? PECD_SEL_CTRL     :
               (paddr == `PECD_OFF_IRQ_STAT) ? PECD_SEL_IRQ_STAT :
               (paddr == `PECD_OFF_IRQ_MASK) ? PECD_SEL_IRQ_MASK :
                                               PECD_SEL_NONE;

  // A transfer completes at the edge where pready is seen high.
  assign pready     = ack & pclk_en;
  assign pslverr    = pready & (sel == PECD_SEL_NONE);
  assign access     = psel & penable & ack & pclk_en;
  assign acc_wr     = access & pwrite;
  assign wr_b_rise  = acc_wr & (sel == PECD_SEL_B_RISE);
  assign wr_b_fall  = acc_wr & (sel == PECD_SEL_B_FALL);
  assign wr_b_flags = acc_wr & (sel == PECD_SEL_B_FLAGS);
  assign wr_c_rise  = acc_wr & (sel == PECD_SEL_C_RISE);
  assign wr_c_fall  = acc_wr & (sel == PECD_SEL_C_FALL);
  assign wr_c_flags = acc_wr & (sel == PECD_SEL_C_FLAGS);
  assign wr_ctrl    = acc_wr & (sel == PECD_SEL_CTRL);
  assign wr_stat    = acc_wr & (sel == PECD_SEL_IRQ_STAT);
  assign wr_mask    = acc_wr & (sel == PECD_SEL_IRQ_MASK);

  // Port B takes the upper nibble; the lower nibble is simply dropped.
  assign wr_data_vec  = {pwdata[C_PINS-1:0], pwdata[`PECD_B_LSB +: B_PINS]};
  assign flag_wr_mask = {{C_PINS{wr_c_flags}}, {B_PINS{wr_b_flags}}};

  // Read data; unimplemented port B bits come back as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (sel)
      PECD_SEL_B_RISE:   rd_mux[`PECD_B_LSB +: B_PINS] = rise_en[B_PINS-1:0];
      PECD_SEL_B_FALL:   rd_mux[`PECD_B_LSB +: B_PINS] = fall_en[B_PINS-1:0];
      PECD_SEL_B_FLAGS:  rd_mux[`PECD_B_LSB +: B_PINS] = flags[B_PINS-1:0];
      PECD_SEL_C_RISE:   rd_mux[C_PINS-1:0] = rise_en[N-1:B_PINS];
      PECD_SEL_C_FALL:   rd_mux[C_PINS-1:0] = fall_en[N-1:B_PINS];
      PECD_SEL_C_FLAGS:  rd_mux[C_PINS-1:0] = flags[N-1:B_PINS];
      PECD_SEL_CTRL: begin
        rd_mux[`PECD_CTRL_IRQ_EN]  = change_irq_enable;
        rd_mux[`PECD_CTRL_SUMMARY] = change_summary_flag;
      end
      PECD_SEL_IRQ_STAT: rd_mux[1:0] = irq_status;
      PECD_SEL_IRQ_MASK: rd_mux[1:0] = irq_mask;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Wait-state flop and registered read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack    <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (pclk_en) begin
      ack <= psel & penable & ~ack;
      if (psel & penable & ~ack) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------
  logic [N-1:0]   pins;
  logic [N-1:0]   rise_evt;
  logic [N-1:0]   fall_evt;
  logic [N-1:0]   set_vec;
  logic           armed;

  assign pins  = {portc_pin_n, portb_pin_n};
  assign armed = (fill == `PECD_FILL_DONE);

  // Two-stage synchroniser, then a previous-level stage for comparison.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
      fill  <= 2'h0;
    end else if (pclk_en) begin
      sync1 <= pins;
      sync2 <= sync1;
      prev  <= sync2;
      if (!armed) begin
        fill <= fill + 2'h1;
      end
    end
  end

  // Per-pin edge qualification and flag next value.
  for (genvar i = 0; i < N; i++) begin : g_pin
    // Edges count only once the pipeline holds real samples.
    assign rise_evt[i] = armed & sync2[i] & ~prev[i];
    assign fall_evt[i] = armed & ~sync2[i] & prev[i];
    // Either enabled direction sets the flag; both enabled catch every edge.
    assign set_vec[i]  = (rise_evt[i] & rise_en[i]) | (fall_evt[i] & fall_en[i]);
    // Hardware set wins over any software write in the same cycle.
    assign next_flags[i] = (flag_wr_mask[i] ? wr_data_vec[i] : flags[i]) | set_vec[i];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Enables, flags and control bits, all cleared by reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_en           <= '0;
      fall_en           <= '0;
      flags             <= '0;
      change_irq_enable <= 1'b0;
    end else if (pclk_en) begin
      if (wr_b_rise) begin
        rise_en[B_PINS-1:0] <= wr_data_vec[B_PINS-1:0];
      end
      if (wr_c_rise) begin
        rise_en[N-1:B_PINS] <= wr_data_vec[N-1:B_PINS];
      end
      if (wr_b_fall) begin
        fall_en[B_PINS-1:0] <= wr_data_vec[B_PINS-1:0];
      end
      if (wr_c_fall) begin
        fall_en[N-1:B_PINS] <= wr_data_vec[N-1:B_PINS];
      end
      if (wr_ctrl) begin
        change_irq_enable <= pwdata[`PECD_CTRL_IRQ_EN];
      end
      flags <= next_flags;
    end
  end

  // ----------------------------------------
  // Summary and interrupts
  // ----------------------------------------
  pecd_evt_t      evt;
  pecd_evt_t      stat_clr;

  // Summary reflects every flag; detection runs regardless of enable.
  assign change_summary_flag = |flags;
  // Core request and wake, held off until the enable is set.
  assign cpu_change_irq = change_summary_flag & change_irq_enable;

  assign evt[`PECD_EVT_B] = |set_vec[B_PINS-1:0];
  assign evt[`PECD_EVT_C] = |set_vec[N-1:B_PINS];
  assign stat_clr         = wr_stat ? pwdata[1:0] : `PECD_RST_EVT;
  assign irq              = |(irq_status & irq_mask);

  // Sticky event bits; write one clears, a new event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `PECD_RST_EVT;
      irq_mask   <= `PECD_RST_EVT;
    end else if (pclk_en) begin
      irq_status <= (irq_status & ~stat_clr) | evt;
      if (wr_mask) begin
        irq_mask <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_B_EDGE_SETS: assert property (
    (pclk_en && |set_vec[B_PINS-1:0]) |=> ((flags[B_PINS-1:0] & $past(set_vec[B_PINS-1:0]))
                                           == $past(set_vec[B_PINS-1:0])))
    else $error("Port B enabled edge did not set its flag.");

  AST_B_LOW_ZERO: assert property (
    (psel && penable && !ack && pclk_en && !pwrite && (sel == PECD_SEL_B_FLAGS ||
     sel == PECD_SEL_B_RISE || sel == PECD_SEL_B_FALL)) |=> (prdata[3:0] == 4'h0))
    else $error("Port B low nibble read back nonzero.");

  AST_C_RISE_SETS: assert property (
    (pclk_en && |(rise_evt[N-1:B_PINS] & rise_en[N-1:B_PINS]))
      |=> ((flags[N-1:B_PINS] & $past(rise_evt[N-1:B_PINS] & rise_en[N-1:B_PINS]))
           == $past(rise_evt[N-1:B_PINS] & rise_en[N-1:B_PINS])))
    else $error("Port C rising edge did not set its flag.");

  AST_C_FALL_SETS: assert property (
    (pclk_en && |(fall_evt[N-1:B_PINS] & fall_en[N-1:B_PINS]))
      |=> ((flags[N-1:B_PINS] & $past(fall_evt[N-1:B_PINS] & fall_en[N-1:B_PINS]))
           == $past(fall_evt[N-1:B_PINS] & fall_en[N-1:B_PINS])))
    else $error("Port C falling edge did not set its flag.");

  AST_NO_STRAY_SET: assert property (
    (pclk_en && !wr_b_flags && !wr_c_flags) |=> ((flags & ~$past(flags) & ~$past(set_vec)) == '0))
    else $error("Flag set without an enabled edge.");

  AST_CLEAR_HOLDS: assert property (
    (wr_c_flags && set_vec[N-1:B_PINS] == '0) |=> (flags[N-1:B_PINS] == $past(pwdata[C_PINS-1:0])))
    else $error("Port C flag write not stored.");

  AST_SUMMARY_SET: assert property (
    (pclk_en && |set_vec) |=> (change_summary_flag && (cpu_change_irq == change_irq_enable)))
    else $error("Summary flag missed or request leaked while disabled.");

  AST_WRITE_RACE: assert property (
    (flag_wr_mask != '0 && |(set_vec & flag_wr_mask)) |=> ((flags & $past(set_vec)) == $past(set_vec)))
    else $error("Edge lost during a flag write.");

  AST_ONE_SET_PER_EDGE: assert property (
    (pclk_en && |set_vec) |=> ((rise_evt & $past(rise_evt)) == '0 && (fall_evt & $past(fall_evt)) == '0))
    else $error("One edge produced two set pulses.");

  AST_IRQ_FOLLOWS: assert property (
    (pclk_en && !wr_mask && evt[`PECD_EVT_C] && irq_mask[`PECD_EVT_C]) |=> irq)
    else $error("Masked-in event did not raise the interrupt.");

  COV_BOTH_EDGES: cover property (
    pclk_en && rise_evt[B_PINS] && rise_en[B_PINS] ##[1:20] pclk_en && fall_evt[B_PINS] && fall_en[B_PINS]);
  COV_RACE: cover property (|(set_vec & flag_wr_mask));
  COV_WAKE: cover property ($rose(cpu_change_irq));

endmodule

`default_nettype wire

/* tb/pecd_pin_model.sv */
// Purpose: Model of the external pins that feed port B and port C.
// Assumes: Pins are driven by ordinary push-pull sources, clean levels.
// Notes:   Levels move one clock after the bench asks for them.
`timescale 1ns/1ps
`default_nettype none

module pecd_pin_model (
  input  wire logic       pclk,
  input  wire logic [3:0] b_want,
  input  wire logic [7:0] c_want,
  output var  logic [3:0] portb_pin_n,
  output var  logic [7:0] portc_pin_n
);
  // --------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------
  // Pins start low and change at most once per clock, so a pulse is never too short.
  initial begin
    portb_pin_n = 4'h0;
    portc_pin_n = 8'h00;
  end

  // Each requested level reaches the pin one clock later.
  always @(posedge pclk) begin
    portb_pin_n <= b_want;
    portc_pin_n <= c_want;
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the pin change detector over APB.
// Assumes: pclk_en stays high, so each access has one wait state.
// Notes:   Pin edges are given six clocks to reach the flags.
`timescale 1ns/1ps
`default_nettype none
`include "pecd_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        summary, cpu_irq, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  b_want, b_pins;
  logic [7:0]  c_want, c_pins;
  int          error_cnt, checks_done;

  pecd_top DUT (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portb_pin_n(b_pins), .portc_pin_n(c_pins),
    .change_summary_flag(summary), .cpu_change_irq(cpu_irq), .irq(irq));

  pecd_pin_model pins (.pclk(pclk), .b_want(b_want), .c_want(c_want),
    .portb_pin_n(b_pins), .portc_pin_n(c_pins));

  // --------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hang is cut short well beyond the expected run length.
  initial begin
    #(25 * 5000);
    error_cnt++;
    conclude();
  end

  // --------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Write one register.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Read one register and compare data and error response.
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(nm, exp, q)
    `CHK("pslverr", exp_err, e)
  endtask

  // Ask for new pin levels and let them pass the synchroniser.
  task automatic drive(input logic [3:0] b, input logic [7:0] c);
    b_want <= b;
    c_want <= c;
    repeat (6) @(posedge pclk);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // --------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------
  // Registers, edge detection, summary, interrupts and a mid-run reset in turn.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    b_want = 4'h0;
    c_want = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 9; i++) rc("reset value", 12'(i * 4), 32'h0000_0000, 1'b0);
    rc("unmapped", 12'h024, 32'h0000_0000, 1'b1);
    wr(`PECD_OFF_B_RISE, 32'h0000_00FF);
    rc("b_rise", `PECD_OFF_B_RISE, 32'h0000_00F0, 1'b0);
    wr(`PECD_OFF_B_FALL, 32'h0000_00FF);
    rc("b_fall", `PECD_OFF_B_FALL, 32'h0000_00F0, 1'b0);
    wr(`PECD_OFF_C_RISE, 32'h0000_000F);
    wr(`PECD_OFF_C_FALL, 32'h0000_00F0);
    rc("c_rise", `PECD_OFF_C_RISE, 32'h0000_000F, 1'b0);
    rc("c_fall", `PECD_OFF_C_FALL, 32'h0000_00F0, 1'b0);
    drive(4'h0, 8'hFF);
    rc("c_flags rise", `PECD_OFF_C_FLAGS, 32'h0000_000F, 1'b0);
    `CHK("summary", 1'b1, summary)
    `CHK("cpu irq off", 1'b0, cpu_irq)
    drive(4'h0, 8'h00);
    rc("c_flags fall", `PECD_OFF_C_FLAGS, 32'h0000_00FF, 1'b0);
    wr(`PECD_OFF_C_FLAGS, 32'h0000_0000);
    rc("c_flags clear", `PECD_OFF_C_FLAGS, 32'h0000_0000, 1'b0);
    `CHK("summary clear", 1'b0, summary)
    // The pin edge is timed so that its flag set meets the access edge of the clearing write.
    c_want <= 8'h01;
    @(posedge pclk);
    wr(`PECD_OFF_C_FLAGS, 32'h0000_0000);
    rc("c_flags race", `PECD_OFF_C_FLAGS, 32'h0000_0001, 1'b0);
    drive(4'h1, 8'h00);
    rc("b_flags rise", `PECD_OFF_B_FLAGS, 32'h0000_0010, 1'b0);
    wr(`PECD_OFF_B_FLAGS, 32'h0000_000F);
    rc("b_flags clear", `PECD_OFF_B_FLAGS, 32'h0000_0000, 1'b0);
    drive(4'h0, 8'h00);
    rc("b_flags fall", `PECD_OFF_B_FLAGS, 32'h0000_0010, 1'b0);
    wr(`PECD_OFF_B_FLAGS, 32'h0000_0000);
    wr(`PECD_OFF_C_FLAGS, 32'h0000_0001);
    rc("c_flags sw set", `PECD_OFF_C_FLAGS, 32'h0000_0001, 1'b0);
    wr(`PECD_OFF_CTRL, 32'h0000_0001);
    rc("ctrl", `PECD_OFF_CTRL, 32'h0000_0003, 1'b0);
    `CHK("cpu irq on", 1'b1, cpu_irq)
    rc("irq status", `PECD_OFF_IRQ_STAT, 32'h0000_0003, 1'b0);
    `CHK("irq masked", 1'b0, irq)
    wr(`PECD_OFF_IRQ_MASK, 32'h0000_0002);
    rc("irq mask", `PECD_OFF_IRQ_MASK, 32'h0000_0002, 1'b0);
    `CHK("irq raised", 1'b1, irq)
    wr(`PECD_OFF_IRQ_STAT, 32'h0000_0002);
    rc("irq status w1c", `PECD_OFF_IRQ_STAT, 32'h0000_0001, 1'b0);
    `CHK("irq cleared", 1'b0, irq)
    drive(4'h0, 8'h02);
    `CHK("irq c event", 1'b1, irq)
    wr(`PECD_OFF_C_FLAGS, 32'h0000_0000);
    `CHK("cpu irq idle", 1'b0, cpu_irq)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("ctrl after reset", `PECD_OFF_CTRL, 32'h0000_0000, 1'b0);
    rc("c_rise after reset", `PECD_OFF_C_RISE, 32'h0000_0000, 1'b0);
    rc("b_fall after reset", `PECD_OFF_B_FALL, 32'h0000_0000, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
